/* File: design/channel_config_word_decoder.sv */
// per-channel configuration word decoder for analog and digital inputs
`timescale 1ns/1ps
`default_nettype none
module channel_config_word_decoder
    import cfg_word_pkg::*;
#(
    parameter int MS_CYCLES  = MS_CYC,
    parameter int OFF_CYCLES = OFF_SLOT_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    // configuration word port
    input  wire logic        analog_cfg_wr,
    input  wire logic        digital_cfg_wr,
    input  wire logic [15:0] cfg_wdata,
    output logic [15:0]      analog_channel_config,
    output logic [15:0]      digital_channel_config,
    output logic             cfg_reserved_err,
    // analog acquisition
    input  wire logic        adc_valid,
    input  wire logic [15:0] adc_value,
    input  wire logic [15:0] range_low,
    input  wire logic [15:0] range_high,
    input  wire logic        sensor_burnout,
    input  wire logic        comp_burnout,
    output logic             analog_valid,
    output logic [15:0]      analog_data,
    output logic [1:0]       sensor_class,
    output logic             four_wire,
    output logic             cj_fixed,
    // digital acquisition
    input  wire logic        dig_scan_start,
    input  wire logic [7:0]  dig_state,
    input  wire logic [7:0]  dig_line_fault,
    output logic             dig_power,
    output logic             dig_valid,
    output logic [15:0]      digital_data
);
    import cfg_word_pkg::*;

    typedef struct packed {
        logic [15:0]      acfg;
        logic [15:0]      dcfg;
        logic [5:0]       a_sns;
        logic [2:0]       a_mode;
        logic [1:0]       a_filt;
        logic [1:0]       d_mode;
        logic [3:0]       d_scan;
        logic             a_pend;
        logic             d_pend;
        logic             rsv_err;
        logic             a_vld;
        logic [15:0]      a_data;
        sensor_class_t    cls;
        logic             four_w;
        logic             cj_fix;
        logic             busy;
        logic [CNT_W-1:0] cnt;
        logic             d_on;
        logic             pwr;
        logic             d_vld;
        logic [15:0]      d_data;
    } dec_state_t;

    dec_state_t s_r;
    dec_state_t s_nxt;

    logic        avg_vld;
    logic [15:0] avg_val;
    logic        avg_clear;
    logic [5:0]  sns_now;
    logic [2:0]  mode_now;

    // scan code to milliseconds
    function automatic logic [5:0] scan_ms(input logic [3:0] code);
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: scan_ms = 6'(code) + 6'h01;
            4'hd:    scan_ms = 6'h19;
            4'he:    scan_ms = 6'h1e;
            4'hf:    scan_ms = 6'h23;
            default: scan_ms = 6'(code - 4'h2) << 1;
        endcase
    endfunction : scan_ms

    function automatic sensor_class_t classify(input logic [5:0] sns);
        if (sns == SNS_OFF) begin
            classify = SENS_OFF_K;
        end else if (sns == SNS_MV1 || sns == SNS_MV2 ||
                     (sns >= SNS_TC_FIRST && sns <= SNS_TC_LAST)) begin
            classify = SENS_VOLT_K;
        end else if (sns == SNS_OHM || (sns >= SNS_RTD_FIRST && sns <= SNS_RTD_LAST)) begin
            classify = SENS_RES_K;
        end else if (sns == SNS_COMP) begin
            classify = SENS_COMP_K;
        end else begin
            classify = SENS_OFF_K;
        end
    endfunction : classify

    assign avg_clear = s_r.a_pend && adc_valid;
    assign sns_now   = s_r.a_pend ? s_r.acfg[A_SENSOR_LSB +: A_SENSOR_W] : s_r.a_sns;
    assign mode_now  = s_r.a_pend ? s_r.acfg[A_MODE_LSB +: A_MODE_W] : s_r.a_mode;

    smart_average #(
        .DEPTH (AVG_MAX)
    ) u_avg (
        .clk          (clk),
        .reset_n      (reset_n),
        .clear        (avg_clear),
        .filt_code    (s_nxt.a_filt),
        .sample_valid (adc_valid && classify(sns_now) != SENS_OFF_K),
        .sample       (adc_value),
        .avg_valid    (avg_vld),
        .avg_out      (avg_val)
    );

    always_comb begin
        s_nxt       = s_r;
        s_nxt.a_vld = 1'b0;
        s_nxt.d_vld = 1'b0;
        // word writes; reserved bits flagged when nonzero
        if (analog_cfg_wr) begin
            s_nxt.acfg    = cfg_wdata;
            s_nxt.a_pend  = 1'b1;
            s_nxt.rsv_err = |(cfg_wdata & A_RSVD_MASK);
        end
        if (digital_cfg_wr) begin
            s_nxt.dcfg    = cfg_wdata;
            s_nxt.d_pend  = 1'b1;
            s_nxt.rsv_err = |(cfg_wdata & D_RSVD_MASK);
        end
        // analog fields latched at the start of the next acquisition
        if (s_r.a_pend && adc_valid && !analog_cfg_wr) begin
            s_nxt.a_sns  = s_r.acfg[A_SENSOR_LSB +: A_SENSOR_W];
            s_nxt.a_mode = s_r.acfg[A_MODE_LSB +: A_MODE_W];
            s_nxt.a_filt = s_r.acfg[A_FILT_LSB +: A_FILT_W];
            s_nxt.a_pend = 1'b0;
        end
        s_nxt.cls    = classify(s_nxt.a_sns);
        s_nxt.four_w = (s_nxt.cls == SENS_RES_K) && (s_nxt.a_mode == 3'h1);
        s_nxt.cj_fix = (s_nxt.cls == SENS_VOLT_K) && s_nxt.a_mode[2];
        // analog result
        if (adc_valid && classify(sns_now) == SENS_OFF_K) begin
            s_nxt.a_vld  = 1'b1;
            s_nxt.a_data = '0;
        end
        if (avg_vld) begin
            s_nxt.a_vld = 1'b1;
            if (s_r.cls == SENS_VOLT_K && (sensor_burnout || comp_burnout ||
                avg_val < range_low || avg_val > range_high)) begin
                case (s_r.a_mode[1:0])
                    BO_CODED: begin
                        if (comp_burnout) begin
                            s_nxt.a_data = CODE_BO_COMP;
                        end else if (sensor_burnout) begin
                            s_nxt.a_data = CODE_BO_SNS;
                        end else if (avg_val < range_low) begin
                            s_nxt.a_data = CODE_UNDER;
                        end else begin
                            s_nxt.a_data = CODE_OVER;
                        end
                    end
                    BO_DOWN: begin
                        s_nxt.a_data = (sensor_burnout || comp_burnout || avg_val < range_low)
                                       ? range_low - 16'h0001 : range_high + 16'h0001;
                    end
                    BO_UP: begin
                        s_nxt.a_data = (sensor_burnout || comp_burnout || avg_val > range_high)
                                       ? range_high + 16'h0001 : range_low - 16'h0001;
                    end
                    default: begin
                        s_nxt.a_data = (avg_val < range_low) ? range_low - 16'h0001
                                       : (avg_val > range_high) ? range_high + 16'h0001 : avg_val;
                    end
                endcase
            end else if (avg_val < range_low) begin
                s_nxt.a_data = range_low - 16'h0001;
            end else if (avg_val > range_high) begin
                s_nxt.a_data = range_high + 16'h0001;
            end else begin
                s_nxt.a_data = avg_val;
            end
        end
        // digital scan slot
        if (!s_r.busy) begin
            if (dig_scan_start) begin
                if (s_r.d_pend && !digital_cfg_wr) begin
                    s_nxt.d_mode = s_r.dcfg[D_MODE_LSB +: D_MODE_W];
                    s_nxt.d_scan = s_r.dcfg[D_SCAN_LSB +: D_SCAN_W];
                    s_nxt.d_pend = 1'b0;
                end
                s_nxt.busy = 1'b1;
                s_nxt.d_on = s_nxt.d_mode[0];
                s_nxt.pwr  = s_nxt.d_mode[0];
                s_nxt.cnt  = s_nxt.d_mode[0]
                             ? CNT_W'(scan_ms(s_nxt.d_scan) * MS_CYCLES - 1)
                             : CNT_W'(OFF_CYCLES - 1);
            end
        end else if (s_r.cnt != '0) begin
            s_nxt.cnt = s_r.cnt - CNT_W'(1);
        end else begin
            s_nxt.busy  = 1'b0;
            s_nxt.pwr   = 1'b0;
            s_nxt.d_vld = 1'b1;
            if (!s_r.d_on) begin
                s_nxt.d_data = '0;
            end else if (s_r.d_mode == DM_ACT_FAULT) begin
                s_nxt.d_data = {dig_line_fault, dig_state};
            end else begin
                s_nxt.d_data = {8'h00, dig_state};
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign analog_channel_config  = s_r.acfg;
    assign digital_channel_config = s_r.dcfg;
    assign cfg_reserved_err       = s_r.rsv_err;
    assign analog_valid           = s_r.a_vld;
    assign analog_data            = s_r.a_data;
    assign sensor_class           = s_r.cls;
    assign four_wire              = s_r.four_w;
    assign cj_fixed               = s_r.cj_fix;
    assign dig_power              = s_r.pwr;
    assign dig_valid              = s_r.d_vld;
    assign digital_data           = s_r.d_data;
endmodule : channel_config_word_decoder
`default_nettype wire

/* File: design/smart_average.sv */
// averaging filter over 1, 2, 4 or 8 converter readings
`timescale 1ns/1ps
`default_nettype none
module smart_average
    import cfg_word_pkg::*;
#(
    parameter int DEPTH = AVG_MAX
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        clear,
    input  wire logic [1:0]  filt_code,
    input  wire logic        sample_valid,
    input  wire logic [15:0] sample,
    output logic             avg_valid,
    output logic [15:0]      avg_out
);
    typedef struct packed {
        logic [DEPTH-1:0][15:0] hist;
        logic [3:0]             fill;
        logic                   vld;
        logic [15:0]            avg;
    } avg_state_t;

    avg_state_t s_r;
    avg_state_t s_nxt;
    logic [18:0] sum;
    logic [3:0]  need;

    always_comb begin
        need = 4'h1 << filt_code;
        sum  = '0;
        for (int i = 0; i < DEPTH; i++) begin
            if (4'(i) < need) begin
                sum = sum + 19'(s_nxt.hist[i]);
            end
        end
    end

    always_comb begin
        s_nxt     = s_r;
        s_nxt.vld = 1'b0;
        // a clearing sample starts the new window, so it still gets a result
        if (sample_valid) begin
            s_nxt.hist = {s_r.hist[DEPTH-2:0], sample};
            if (clear) begin
                s_nxt.fill = 4'h1;
            end else if (s_r.fill < need) begin
                s_nxt.fill = s_r.fill + 4'h1;
            end
        end else if (clear) begin
            s_nxt.fill = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
            if (sample_valid) begin
                // average over the window; the latest sample alone until it has filled
                s_r.vld <= 1'b1;
                s_r.avg <= (s_nxt.fill >= need) ? 16'(sum >> filt_code) : sample;
            end
        end
    end

    assign avg_valid = s_r.vld;
    assign avg_out   = s_r.avg;
endmodule : smart_average
`default_nettype wire

/* File: inc/cfg_word_pkg.sv */
// constants and types for the channel configuration word decoder
package cfg_word_pkg;
    localparam int        WORD_W         = 16;
    // analog word fields
    localparam int        A_SENSOR_LSB   = 0;
    localparam int        A_SENSOR_W     = 6;
    localparam int        A_MODE_LSB     = 7;
    localparam int        A_MODE_W       = 3;
    localparam int        A_FILT_LSB     = 11;
    localparam int        A_FILT_W       = 2;
    localparam logic [15:0] A_RSVD_MASK  = 16'he440;
    // digital word fields
    localparam int        D_MODE_LSB     = 0;
    localparam int        D_MODE_W       = 2;
    localparam int        D_SCAN_LSB     = 3;
    localparam int        D_SCAN_W       = 4;
    localparam logic [15:0] D_RSVD_MASK  = 16'hff84;
    // sensor code boundaries
    localparam logic [5:0] SNS_OFF       = 6'h00;
    localparam logic [5:0] SNS_MV1       = 6'h01;
    localparam logic [5:0] SNS_MV2       = 6'h02;
    localparam logic [5:0] SNS_OHM       = 6'h03;
    localparam logic [5:0] SNS_TC_FIRST  = 6'h04;
    localparam logic [5:0] SNS_TC_LAST   = 6'h12;
    localparam logic [5:0] SNS_RTD_FIRST = 6'h13;
    localparam logic [5:0] SNS_RTD_LAST  = 6'h1d;
    localparam logic [5:0] SNS_COMP      = 6'h1e;
    // coded burnout values
    localparam logic [15:0] CODE_UNDER   = 16'h7d00;
    localparam logic [15:0] CODE_OVER    = 16'h7d01;
    localparam logic [15:0] CODE_BO_SNS  = 16'h7d02;
    localparam logic [15:0] CODE_BO_COMP = 16'h7d03;
    // burnout handling codes
    localparam logic [1:0] BO_NONE       = 2'h0;
    localparam logic [1:0] BO_DOWN       = 2'h1;
    localparam logic [1:0] BO_UP         = 2'h2;
    localparam logic [1:0] BO_CODED      = 2'h3;
    // digital modes
    localparam logic [1:0] DM_OFF        = 2'h0;
    localparam logic [1:0] DM_ACT        = 2'h1;
    localparam logic [1:0] DM_OFF2       = 2'h2;
    localparam logic [1:0] DM_ACT_FAULT  = 2'h3;
    // timing
    localparam int        CLK_HZ         = 25_000_000;
    localparam int        OFF_SLOT_US    = 500;
    localparam int        OFF_SLOT_CYC   = OFF_SLOT_US * (CLK_HZ / 1_000_000);
    localparam int        MS_CYC         = CLK_HZ / 1000;
    localparam int        CNT_W          = 20;
    localparam int        AVG_MAX        = 8;

    typedef enum logic [1:0] {
        SENS_OFF_K, SENS_VOLT_K, SENS_RES_K, SENS_COMP_K
    } sensor_class_t;
endpackage : cfg_word_pkg

/* File: testbench/channel_config_word_decoder_properties.sv */
// port checks for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module channel_config_word_decoder_properties
    import cfg_word_pkg::*;
#(
    parameter int MS_CYCLES  = MS_CYC,
    parameter int OFF_CYCLES = OFF_SLOT_CYC
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        analog_cfg_wr,
    input wire logic        digital_cfg_wr,
    input wire logic [15:0] cfg_wdata,
    input wire logic [15:0] analog_channel_config,
    input wire logic [15:0] digital_channel_config,
    input wire logic        cfg_reserved_err,
    input wire logic        adc_valid,
    input wire logic        analog_valid,
    input wire logic [15:0] analog_data,
    input wire logic [1:0]  sensor_class,
    input wire logic        dig_power,
    input wire logic        dig_valid,
    input wire logic [15:0] digital_data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    chk_analog_write: assert property (analog_cfg_wr |=> analog_channel_config == $past(cfg_wdata))
        else $error("analog word not stored");
    chk_analog_reserved: assert property (analog_cfg_wr |=> cfg_reserved_err == |($past(cfg_wdata) & A_RSVD_MASK))
        else $error("analog reserved flag wrong");
    chk_digital_write: assert property (digital_cfg_wr |=> digital_channel_config == $past(cfg_wdata)
        && cfg_reserved_err == |($past(cfg_wdata) & D_RSVD_MASK)) else $error("digital word not stored");
    chk_config_hold: assert property (!(analog_cfg_wr || digital_cfg_wr) |=>
        $stable(analog_channel_config) && $stable(digital_channel_config)) else $error("config moved");
    chk_analog_answer: assert property (adc_valid |-> ##[1:2] analog_valid)
        else $error("no analog result");
    chk_off_zero: assert property (analog_valid && sensor_class == 2'h0 |-> analog_data == 16'h0000)
        else $error("off channel data not zero");
    chk_dig_off_zero: assert property (dig_valid && !digital_channel_config[0] |-> digital_data == 16'h0000)
        else $error("disabled digital data not zero");
    chk_fault_byte_off: assert property (dig_valid && digital_channel_config[1:0] == DM_ACT |->
        digital_data[15:8] == 8'h00) else $error("fault byte set without detection");
    chk_power_active: assert property (dig_power |-> digital_channel_config[0])
        else $error("power in disabled mode");
    chk_slot_result: assert property ($fell(dig_power) |-> ##[0:1] dig_valid)
        else $error("no result after power slot");
endmodule : channel_config_word_decoder_properties
`default_nettype wire

/* File: testbench/channel_config_word_decoder_test.sv */
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module channel_config_word_decoder_test;
    import cfg_word_pkg::*;
    localparam int MS_CYCLES  = 4;
    localparam int OFF_CYCLES = 2;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        analog_cfg_wr = 1'b0;
    logic        digital_cfg_wr = 1'b0;
    logic        dig_scan_start = 1'b0;
    logic [15:0] cfg_wdata = 16'h0000;
    logic [15:0] range_low = 16'h0010;
    logic [15:0] range_high = 16'h0f00;
    logic        adc_valid, sensor_burnout, comp_burnout, err, analog_valid, four_wire, cj_fixed, dig_power, dig_valid;
    logic [1:0]  sensor_class;
    logic [7:0]  dig_state, dig_line_fault;
    logic [15:0] adc_value, acfg, dcfg, analog_data, digital_data;
    int          n_errors = 0;
    int          checks = 0;
    channel_config_word_decoder #(.MS_CYCLES(MS_CYCLES), .OFF_CYCLES(OFF_CYCLES)) DUT (.clk(clk), .reset_n(reset_n),
        .analog_cfg_wr(analog_cfg_wr), .digital_cfg_wr(digital_cfg_wr), .cfg_wdata(cfg_wdata),
        .analog_channel_config(acfg), .digital_channel_config(dcfg), .cfg_reserved_err(err),
        .adc_valid(adc_valid), .adc_value(adc_value), .range_low(range_low), .range_high(range_high),
        .sensor_burnout(sensor_burnout), .comp_burnout(comp_burnout), .analog_valid(analog_valid),
        .analog_data(analog_data), .sensor_class(sensor_class), .four_wire(four_wire), .cj_fixed(cj_fixed),
        .dig_scan_start(dig_scan_start), .dig_state(dig_state), .dig_line_fault(dig_line_fault),
        .dig_power(dig_power), .dig_valid(dig_valid), .digital_data(digital_data));
    field_sensor_model PM (.clk(clk), .dig_power(dig_power), .adc_valid(adc_valid), .adc_value(adc_value),
        .sensor_burnout(sensor_burnout), .comp_burnout(comp_burnout), .dig_state(dig_state),
        .dig_line_fault(dig_line_fault));
    always #20 clk = ~clk;
    task automatic tick;
        @(posedge clk);
        #1;
    endtask : tick
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic final_report;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report
    task automatic write_cfg(input logic dig, input logic [15:0] w);
        analog_cfg_wr = !dig;
        digital_cfg_wr = dig;
        cfg_wdata = w;
        tick();
        analog_cfg_wr = 1'b0;
        digital_cfg_wr = 1'b0;
        tick();
    endtask : write_cfg
    task automatic acquire(input logic [15:0] v, input logic sb, input logic cb, output logic [15:0] d);
        PM.convert(v, sb, cb);
        d = 16'hxxxx;
        for (int i = 0; i < 4; i++) begin
            if (analog_valid === 1'b1)
                d = analog_data;
            tick();
        end
    endtask : acquire
    task automatic sensor_codes;
        logic [15:0] d;
        logic [1:0]  c;
        for (int s = 0; s <= 30; s++) begin
            c = (s == 0) ? 2'h0 : (s == 30) ? 2'h3 : (s == 3 || s >= 19) ? 2'h2 : 2'h1;
            write_cfg(1'b0, 16'(s));
            acquire(16'h0100, 1'b0, 1'b0, d);
            chk("sensor_class", {14'h0, c}, {14'h0, sensor_class});
            chk("analog_data", (s == 0) ? 16'h0000 : 16'h0100, d);
        end
    endtask : sensor_codes
    task automatic burnout_modes;
        logic [15:0] d;
        logic [15:0] e [4];
        e = '{16'h0100, range_low - 16'h0001, range_high + 16'h0001, CODE_BO_SNS};
        for (int m = 0; m < 8; m++) begin
            write_cfg(1'b0, 16'(m * 128 + 7));
            acquire(16'h0100, 1'b1, 1'b0, d);
            chk("burnout", e[m % 4], d);
            chk("cj_fixed", 16'(m / 4), {15'h0, cj_fixed});
        end
        acquire(16'h0100, 1'b0, 1'b1, d);
        chk("comp burnout", CODE_BO_COMP, d);
        acquire(16'h0005, 1'b0, 1'b0, d);
        chk("under", CODE_UNDER, d);
        acquire(16'hf000, 1'b0, 1'b0, d);
        chk("over", CODE_OVER, d);
        write_cfg(1'b0, 16'h0087);
        acquire(16'h0005, 1'b0, 1'b0, d);
        chk("under plain", range_low - 16'h0001, d);
    endtask : burnout_modes
    task automatic wiring;
        logic [15:0] d;
        logic [15:0] w [3];
        w = '{16'h0093, 16'h0013, 16'h0083};
        for (int i = 0; i < 3; i++) begin
            write_cfg(1'b0, w[i]);
            acquire(16'h0100, 1'b0, 1'b0, d);
            chk("four_wire", {15'h0, w[i][7]}, {15'h0, four_wire});
        end
    endtask : wiring
    task automatic filters;
        logic [15:0] d;
        for (int f = 0; f < 4; f++) begin
            write_cfg(1'b0, 16'(f * 2048 + 1));
            for (int i = 0; i < (1 << f); i++)
                acquire(16'h0064 + 16'(2 * i), 1'b0, 1'b0, d);
            chk("average", 16'h0063 + 16'(1 << f), d);
        end
    endtask : filters
    task automatic reserved_bits;
        write_cfg(1'b0, A_RSVD_MASK | 16'h0007);
        chk("analog cfg", A_RSVD_MASK | 16'h0007, acfg);
        chk("reserved err", 16'h0001, {15'h0, err});
        write_cfg(1'b1, 16'h0001);
        chk("reserved err", 16'h0000, {15'h0, err});
        write_cfg(1'b1, 16'h0004);
        chk("reserved err", 16'h0001, {15'h0, err});
        chk("digital cfg", 16'h0004, dcfg);
    endtask : reserved_bits
    task automatic scan(input logic [15:0] w, output int total, output int pwr);
        write_cfg(1'b1, w);
        dig_scan_start = 1'b1;
        tick();
        dig_scan_start = 1'b0;
        total = 0;
        pwr = 0;
        while (dig_valid !== 1'b1 && total < 400) begin
            pwr += (dig_power === 1'b1);
            total++;
            tick();
        end
    endtask : scan
    task automatic digital_slots;
        int         ms [16] = '{1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 16, 18, 20, 25, 30, 35};
        int         total, pwr, base;
        logic [1:0] m;
        for (int c = 0; c < 16; c++) begin
            m = (c % 2 == 1) ? DM_ACT_FAULT : DM_ACT;
            scan(16'(c * 8) | {14'h0, m}, total, pwr);
            chk("power time", 16'(ms[c] * MS_CYCLES), 16'(pwr));
            chk("digital data", {(m == DM_ACT_FAULT) ? PM.flt : 8'h00, PM.st}, digital_data);
            if (c == 0)
                base = total - pwr;
        end
        for (int k = 0; k < 2; k++) begin
            scan(16'h0078 | 16'(k * 2), total, pwr);
            chk("off power", 16'h0000, 16'(pwr));
            chk("off slot", 16'(base + OFF_CYCLES), 16'(total));
            chk("off data", 16'h0000, digital_data);
        end
    endtask : digital_slots
    initial begin
        repeat (6) @(posedge clk);
        #1;
        reset_n = 1'b1;
        chk("analog cfg reset", 16'h0000, acfg);
        chk("digital cfg reset", 16'h0000, dcfg);
        sensor_codes();
        burnout_modes();
        wiring();
        filters();
        reserved_bits();
        digital_slots();
        final_report();
    end
    initial begin
        #2000000;
        n_errors++;
        $display("[FAIL] watchdog expected done seen timeout");
        final_report();
    end
endmodule : channel_config_word_decoder_test
bind channel_config_word_decoder channel_config_word_decoder_properties #(.MS_CYCLES(MS_CYCLES),
    .OFF_CYCLES(OFF_CYCLES)) u_chk (.clk(clk), .reset_n(reset_n), .analog_cfg_wr(analog_cfg_wr),
    .digital_cfg_wr(digital_cfg_wr), .cfg_wdata(cfg_wdata), .analog_channel_config(analog_channel_config),
    .digital_channel_config(digital_channel_config), .cfg_reserved_err(cfg_reserved_err), .adc_valid(adc_valid),
    .analog_valid(analog_valid), .analog_data(analog_data), .sensor_class(sensor_class), .dig_power(dig_power),
    .dig_valid(dig_valid), .digital_data(digital_data));
`default_nettype wire

/* File: testbench/field_sensor_model.sv */
// behavioural field sensors and contacts
`timescale 1ns/1ps
`default_nettype none
module field_sensor_model (
    input  wire logic        clk,
    input  wire logic        dig_power,
    output logic             adc_valid,
    output logic [15:0]      adc_value,
    output logic             sensor_burnout,
    output logic             comp_burnout,
    output logic [7:0]       dig_state,
    output logic [7:0]       dig_line_fault
);
    logic [7:0] st = 8'ha5;
    logic [7:0] flt = 8'h3c;
    initial begin
        adc_valid = 1'b0;
        adc_value = 16'h0000;
        sensor_burnout = 1'b0;
        comp_burnout = 1'b0;
    end
    // unpowered contacts give no valid level
    assign dig_state      = dig_power ? st : ~st;
    assign dig_line_fault = dig_power ? flt : ~flt;
    task automatic convert(input logic [15:0] v, input logic sb, input logic cb);
        @(posedge clk);
        #1;
        adc_value = v;
        sensor_burnout = sb;
        comp_burnout = cb;
        adc_valid = 1'b1;
        @(posedge clk);
        #1;
        adc_valid = 1'b0;
        adc_value = ~v;
    endtask : convert
endmodule : field_sensor_model
`default_nettype wire
